// ===== hw/receiver_mode_control_bank.sv
module receiver_mode_control_bank
   import rx_ctrl_pkg::*;
#(
   parameter int DW = 11
)(
   input  wire logic                      clock_i,
   input  wire logic                      nrst_i,
   input  wire logic                      spi_clk_i,
   input  wire logic                      spi_cs_n_i,
   input  wire logic                      spi_data_i,
   output logic                           spi_data_o,
   output logic                           spi_data_oe_o,
   input  wire logic                      power_down_pin_i,
   input  wire logic                      sysref_i,
   input  wire logic                      link_sync_request_n_i,
   input  wire logic signed [DW-1:0]      sample_i,
   output logic             [DW-1:0]      sample_o,
   output logic             [1:0]         converter_mode_o,
   output logic             [1:0]         link_mode_o,
   output logic                           pll_on_o,
   output logic                           serializer_on_o,
   output logic                           link_clocks_on_o,
   output logic                           link_reset_o,
   output logic                           driver_power_down_o,
   output logic             [2:0]         control_bit_select_o,
   output logic                           requantizer_enable_o,
   output logic                           requantizer_wide_o,
   output logic             [5:0]         requantizer_tuning_o,
   output logic                           divider_reset_o,
   output logic                           link_realign_o,
   output logic                           sync_request_o,
   output logic             [7:0]         multiframe_offset_o,
   output logic             [7:0]         transmit_emphasis_o,
   output logic             [15:0]        dc_value_o
);
   import rx_ctrl_pkg::*;

   localparam int AW = DW + DC_K_BASE + 13;

   typedef enum logic [2:0]
   {
      PH_IDLE  = 3'b001,
      PH_INSTR = 3'b010,
      PH_DATA  = 3'b100
   } phase_t;

   typedef struct packed
   {
      logic [2:0]                 clk_s;
      logic [1:0]                 cs_s;
      logic [1:0]                 din_s;
      logic [1:0]                 pin_s;
      logic [2:0]                 sref_s;
      logic [1:0]                 sync_s;
      phase_t                     phase;
      logic [4:0]                 cnt;
      logic [15:0]                sh;
      logic                       rw;
      logic [12:0]                addr;
      logic [7:0]                 rd_sh;
      logic                       dout;
      logic                       oe;
      logic [NUM_REGS-1:0][7:0]   shadow;
      logic [NUM_REGS-1:0][7:0]   act;
      logic                       xfer;
      logic                       sref_armed;
      logic                       sync_buf;
      logic signed [AW-1:0]       acc;
      logic [DW-1:0]              data;
      logic [1:0]                 conv_mode;
      logic [1:0]                 link_mode;
      logic                       div_rst;
      logic                       realign;
      logic [5:0]                 tune;
      logic                       pll;
      logic                       ser;
      logic                       lck;
      logic                       lrst;
      logic signed [15:0]         dcv;
   } state_t;

   state_t r;
   state_t n;
   logic [1:0] rst_q;
   logic       rst_n;

   // ****************************************************************
   // Reset release
   // ****************************************************************
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rst_q <= 2'b00;
      else
         rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   // ****************************************************************
   // Next state
   // ****************************************************************
   logic               clk_rise;
   logic               clk_fall;
   logic [15:0]        word;
   logic [7:0]         rd_data;
   logic               wr_en;
   logic [7:0]         wr_data;
   logic               pin_on;
   logic               sref_rise;
   logic               sync_rise;
   logic [3:0]         dc_k;
   logic signed [AW-1:0] est;
   logic signed [DW:0] diff;
   logic [DW-1:0]      val;

   always_comb
   begin
      n = r;
      rd_data = 8'h00;
      diff = '0;
      wr_en = 1'b0;
      wr_data = {r.sh[6:0], r.din_s[1]};
      // Pins: logic uses the second stage; SPI clock and SYSREF also use the third stage for edges
      n.clk_s  = {r.clk_s[1:0], spi_clk_i};
      n.cs_s   = {r.cs_s[0], spi_cs_n_i};
      n.din_s  = {r.din_s[0], spi_data_i};
      n.pin_s  = {r.pin_s[0], power_down_pin_i};
      n.sref_s = {r.sref_s[1:0], sysref_i};
      n.sync_s = {r.sync_s[0], link_sync_request_n_i};
      clk_rise = r.clk_s[1] & ~r.clk_s[2];
      clk_fall = ~r.clk_s[1] & r.clk_s[2];
      word = {r.sh[14:0], r.din_s[1]};
      for (int i = 0; i < NUM_REGS; i++)
      begin
         if (word[12:0] == REG_ADDR[i])
            rd_data = r.shadow[i];
      end
      if (word[12:0] == ADDR_XFER)
         rd_data = {7'h00, r.xfer};

      // Serial control port: 16-bit instruction, one data byte
      if (r.cs_s[1])
      begin
         n.phase = PH_IDLE;
         n.cnt = 5'h00;
         n.oe = 1'b0;
      end
      else
      begin
         unique case (r.phase)
            PH_IDLE:
            begin
               n.phase = PH_INSTR;
               n.cnt = 5'h00;
            end
            PH_INSTR:
            begin
               if (clk_rise)
               begin
                  n.sh = word;
                  n.cnt = r.cnt + 5'h01;
                  if (r.cnt == INSTR_BITS - 5'h01)
                  begin
                     n.rw = word[15];
                     n.addr = word[12:0];
                     n.rd_sh = rd_data;
                     n.cnt = 5'h00;
                     n.phase = PH_DATA;
                  end
               end
            end
            PH_DATA:
            begin
               if (r.rw && clk_fall)
               begin
                  n.oe = (r.cnt < DATA_BITS);
                  n.dout = r.rd_sh[7];
                  n.rd_sh = {r.rd_sh[6:0], 1'b0};
               end
               // Extra bytes in a stream are ignored rather than auto-incremented
               if (clk_rise && r.cnt < DATA_BITS)
               begin
                  n.sh = word;
                  n.cnt = r.cnt + 5'h01;
                  wr_en = !r.rw && (r.cnt == DATA_BITS - 5'h01);
               end
            end
            default:
               n.phase = PH_IDLE;
         endcase
      end

      // Settings take effect only on transfer
      if (r.xfer)
      begin
         n.act = r.shadow;
         n.xfer = 1'b0;
         n.sref_armed = r.shadow[IX_LSC][B_SREF_MODE];
      end
      if (wr_en)
      begin
         for (int i = 0; i < NUM_REGS; i++)
         begin
            if (r.addr == REG_ADDR[i])
               n.shadow[i] = wr_data;
         end
         // A new request set in the clearing cycle is kept
         if (r.addr == ADDR_XFER && wr_data[B_XFER])
            n.xfer = 1'b1;
      end

      // Power modes
      pin_on = r.pin_s[1];
      n.conv_mode = r.act[IX_PDM][B_CONV_PWR +: 2];
      n.link_mode = r.act[IX_PDM][B_LINK_PWR +: 2];
      if (n.link_mode == 2'b11)
         n.link_mode = PWR_NORMAL;
      if (n.conv_mode == 2'b11)
         n.conv_mode = PWR_NORMAL;
      if (pin_on && !r.act[IX_PDM][B_PIN_FUNC])
      begin
         n.conv_mode = PWR_DOWN;
         n.link_mode = PWR_DOWN;
      end
      else if (pin_on)
      begin
         n.conv_mode = PWR_STANDBY;
         if (r.act[IX_PDM][B_LINK_STBY])
            n.link_mode = PWR_STANDBY;
      end
      // Link enables come from flops so they cannot glitch while the mode settles
      n.pll  = (n.link_mode != PWR_DOWN);
      n.ser  = (n.link_mode == PWR_NORMAL);
      n.lck  = (n.link_mode == PWR_NORMAL);
      n.lrst = (n.link_mode != PWR_NORMAL);

      // SYSREF and sync request
      sref_rise = r.sref_s[1] & ~r.sref_s[2] & r.act[IX_LSC][B_SREF_EN];
      n.sync_buf = ~r.sync_s[1] & r.act[IX_LSC][B_SYNC_BUF];
      sync_rise = n.sync_buf & ~r.sync_buf;
      n.div_rst = 1'b0;
      if (sref_rise && !r.act[IX_LSC][B_SREF_MODE])
         n.div_rst = 1'b1;
      else if (sref_rise && r.sref_armed && !r.xfer)
      begin
         n.div_rst = 1'b1;
         n.sref_armed = 1'b0;
      end
      n.realign = (sref_rise && r.act[IX_LSC][B_SREF_REALIGN])
               || (sync_rise && r.act[IX_LSC][B_SYNC_REALIGN]);

      // Requantizer tuning limited to the valid range of the band mode
      n.tune = r.act[IX_RQT][5:0];
      if (r.act[IX_RQC][B_RQ_WIDE] && n.tune > TUNE_MAX_WIDE)
         n.tune = TUNE_MAX_WIDE;
      else if (!r.act[IX_RQC][B_RQ_WIDE] && n.tune > TUNE_MAX_NARROW)
         n.tune = TUNE_MAX_NARROW;

      // DC estimate: leaky average, narrow bandwidth needs a wide accumulator
      dc_k = r.act[IX_OCC][B_DC_BW +: 4];
      if (dc_k > DC_K_MAX)
         dc_k = DC_K_MAX;
      est = r.acc >>> (5'(dc_k) + 5'(DC_K_BASE));
      if (!r.act[IX_OCC][B_DC_FREEZE])
         n.acc = r.acc + AW'(sample_i) - est;
      // Published estimate lags the accumulator by one cycle
      n.dcv = 16'(est);

      // Output data path
      val = sample_i;
      if (r.act[IX_OCC][B_DC_EN])
      begin
         diff = {sample_i[DW-1], sample_i} - {est[DW-1], est[DW-1:0]};
         if (diff[DW] != diff[DW-1])
            val = {diff[DW], {(DW-1){~diff[DW]}}};
         else
            val = diff[DW-1:0];
      end
      if (r.act[IX_OMC][B_INVERT])
         val = ~val;
      if (r.act[IX_OMC][B_FORMAT +: 2] == FMT_OFFSET)
         val[DW-1] = ~val[DW-1];
      n.data = r.act[IX_OMC][B_OUT_DIS] ? '0 : val;
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r <= '0;
         r.clk_s <= 3'h0;
         r.cs_s <= 2'h3;
         r.sync_s <= 2'h3;
         r.phase <= PH_IDLE;
         r.shadow <= REG_RESET;
         r.act <= REG_RESET;
         r.pll <= 1'b1;
         r.ser <= 1'b1;
         r.lck <= 1'b1;
      end
      else
         r <= n;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign spi_data_o           = r.dout;
   assign spi_data_oe_o        = r.oe;
   assign sample_o             = r.data;
   assign converter_mode_o     = r.conv_mode;
   assign link_mode_o          = r.link_mode;
   assign pll_on_o             = r.pll;
   assign serializer_on_o      = r.ser;
   assign link_clocks_on_o     = r.lck;
   assign link_reset_o         = r.lrst;
   assign driver_power_down_o  = r.act[IX_DRV][B_DRV_PD];
   assign control_bit_select_o = r.act[IX_OMC][B_CS_SEL +: 3];
   assign requantizer_enable_o = r.act[IX_RQC][B_RQ_EN];
   assign requantizer_wide_o   = r.act[IX_RQC][B_RQ_WIDE];
   assign requantizer_tuning_o = r.tune;
   assign divider_reset_o      = r.div_rst;
   assign link_realign_o       = r.realign;
   assign sync_request_o       = r.sync_buf;
   assign multiframe_offset_o  = r.act[IX_LMFC];
   assign transmit_emphasis_o  = r.act[IX_EMPH];
   assign dc_value_o           = r.dcv;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n);

   xfer_applies_a: assert property (r.xfer |=> r.act == $past(r.shadow))
      else $error("transfer did not apply shadow settings");
   xfer_clears_a: assert property (r.xfer && !wr_en |=> !r.xfer)
      else $error("transfer bit did not clear");
   pin_full_down_a: assert property ((pin_on && !r.act[IX_PDM][B_PIN_FUNC])
      |=> converter_mode_o == PWR_DOWN && link_mode_o == PWR_DOWN)
      else $error("pin did not power down device");
   link_standby_a: assert property ((pin_on && r.act[IX_PDM][B_PIN_FUNC]
      && r.act[IX_PDM][B_LINK_STBY]) |=> link_mode_o == PWR_STANDBY && pll_on_o)
      else $error("link not in standby with pll on");
   sysref_gated_a: assert property (!r.act[IX_LSC][B_SREF_EN] && !r.xfer
      |=> !divider_reset_o)
      else $error("disabled sysref reset dividers");
   sync_buffer_off_a: assert property (!r.act[IX_LSC][B_SYNC_BUF] && !r.xfer
      |=> !sync_request_o)
      else $error("sync request passed disabled buffer");
   out_disable_a: assert property (r.act[IX_OMC][B_OUT_DIS] && !r.xfer
      |=> sample_o == '0)
      else $error("output data not disabled");
   tune_range_a: assert property (requantizer_wide_o && !$past(r.xfer)
      |-> requantizer_tuning_o <= TUNE_MAX_WIDE)
      else $error("tuning word out of range");
   dc_freeze_a: assert property (r.act[IX_OCC][B_DC_FREEZE] && !r.xfer
      |=> $stable(r.acc))
      else $error("frozen dc estimate changed");
   oneshot_sysref_a: assert property (divider_reset_o && r.act[IX_LSC][B_SREF_MODE]
      && !$past(r.xfer) |-> !r.sref_armed)
      else $error("one-shot divider reset rearmed");
   dc_bypass_a: assert property (!r.act[IX_OCC][B_DC_EN] && !r.xfer
      && !r.act[IX_OMC][B_OUT_DIS] && !r.act[IX_OMC][B_INVERT]
      && r.act[IX_OMC][B_FORMAT +: 2] != FMT_OFFSET |=> sample_o == $past(sample_i))
      else $error("uncorrected sample altered");

   xfer_seen_c: cover property (wr_en && r.addr == ADDR_XFER ##1 r.xfer ##1 !r.xfer);
   read_seen_c: cover property (r.oe && r.rw);
   realign_seen_c: cover property (link_realign_o);
   standby_seen_c: cover property (link_mode_o == PWR_STANDBY);

endmodule // receiver_mode_control_bank

// ===== hw/rx_ctrl_pkg.sv
// Behaviour
// - Pin function bit clear: power-down pin powers down fully; set: standby.
// - Link standby bit puts link into standby when pin asserted and standby selected.
// - Link power field: 00 normal, 01 power-down, 10 standby with PLL kept on.
// - Converter power field: 00 normal, 01 power-down, 10 standby.
// - Three-bit field selects meaning of control bits carried with each sample.
// - Output disable bit stops converter output data.
// - Data invert bit inverts converter output data.
// - Data format 00 gives offset binary, 01 gives two's complement.
// - Sync realign bit realigns link on every sync request assertion.
// - SYSREF realign bit realigns link on every SYSREF assertion.
// - SYSREF mode clear resets dividers every assertion; set, only next rising edge.
// - SYSREF enable bit clear makes SYSREF activity ineffective.
// - Sync buffer enable bit gates the sync request input buffer.
// - Requantizer bandwidth bit: 22% band when clear, 33% when set.
// - Requantizer processes data only while its enable bit is high.
// - Six-bit tuning word; 57 valid values narrow mode, 34 wide mode.
// - Freeze bit high holds DC estimate; low updates it continuously.
// - DC bandwidth 2^(-k-14) of rate; k of 14 or 15 acts as 13.
// - DC correction enabled removes measured offset from the signal path.
// - Offset register, reset zero, feeds the multiframe phase counter.
package rx_ctrl_pkg;
   localparam int          NUM_REGS      = 11;
   localparam logic [12:0] ADDR_PDM      = 13'h0008;
   localparam logic [12:0] ADDR_OMC      = 13'h0014;
   localparam logic [12:0] ADDR_LSC      = 13'h003a;
   localparam logic [12:0] ADDR_RQC      = 13'h003c;
   localparam logic [12:0] ADDR_RQT      = 13'h003e;
   localparam logic [12:0] ADDR_OCC      = 13'h0040;
   localparam logic [12:0] ADDR_SCRATCH  = 13'h0077;
   localparam logic [12:0] ADDR_LANE_CHECKSUM   = 13'h0079;
   localparam logic [12:0] ADDR_DRV      = 13'h0080;
   localparam logic [12:0] ADDR_LMFC     = 13'h008b;
   localparam logic [12:0] ADDR_EMPH     = 13'h00a8;
   localparam logic [12:0] ADDR_XFER     = 13'h00ff;
   localparam int IX_PDM = 0, IX_OMC = 1, IX_LSC = 2, IX_RQC = 3, IX_RQT = 4, IX_OCC = 5;
   localparam int IX_SCRATCH = 6, IX_LANE_CHECKSUM = 7, IX_DRV = 8, IX_LMFC = 9, IX_EMPH = 10;
   localparam logic [NUM_REGS-1:0][12:0] REG_ADDR = {ADDR_EMPH, ADDR_LMFC, ADDR_DRV,
      ADDR_LANE_CHECKSUM, ADDR_SCRATCH, ADDR_OCC, ADDR_RQT, ADDR_RQC, ADDR_LSC, ADDR_OMC, ADDR_PDM};
   localparam logic [7:0]  RST_DEFAULT   = 8'h00;
   localparam logic [7:0]  RST_DRV       = 8'h00;
   localparam logic [7:0]  RST_LMFC      = 8'h00;
   localparam logic [7:0]  RST_EMPH      = 8'h04;
   localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {RST_EMPH, RST_LMFC, RST_DRV,
      RST_DEFAULT, RST_DEFAULT, RST_DEFAULT, RST_DEFAULT, RST_DEFAULT, RST_DEFAULT,
      RST_DEFAULT, RST_DEFAULT};
   // Field positions
   localparam int B_PIN_FUNC = 5, B_LINK_STBY = 4, B_LINK_PWR = 2, B_CONV_PWR = 0;
   localparam int B_CS_SEL = 5, B_OUT_DIS = 4, B_INVERT = 2, B_FORMAT = 0;
   localparam int B_SYNC_REALIGN = 4, B_SREF_REALIGN = 3, B_SREF_MODE = 2;
   localparam int B_SREF_EN = 1, B_SYNC_BUF = 0;
   localparam int B_RQ_WIDE = 1, B_RQ_EN = 0, B_DC_FREEZE = 6, B_DC_BW = 2, B_DC_EN = 1;
   localparam int B_DRV_PD = 0, B_XFER = 0;
   // Power and format codes
   localparam logic [1:0]  PWR_NORMAL    = 2'b00;
   localparam logic [1:0]  PWR_DOWN      = 2'b01;
   localparam logic [1:0]  PWR_STANDBY   = 2'b10;
   localparam logic [1:0]  FMT_OFFSET    = 2'b00;
   // Requantizer and DC limits
   localparam logic [5:0]  TUNE_MAX_NARROW = 6'h38;
   localparam logic [5:0]  TUNE_MAX_WIDE   = 6'h21;
   localparam logic [3:0]  DC_K_MAX        = 4'hd;
   localparam int          DC_K_BASE       = 14;
   // Serial port framing
   localparam logic [4:0]  INSTR_BITS    = 5'h10;
   localparam logic [4:0]  DATA_BITS     = 5'h08;
endpackage

// ===== tb/host_model.sv
module host_model (
   input  wire logic clock_i,
   input  wire logic data_i,
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      data_o,
   output logic      data_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Serial port master, slow clock
   // ****************************************
   // Each clock level lasts 6 cycles so read data, which lags a fall by about 3, is settled
   initial
   begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      data_o = 1'b0;
      data_oe_o = 1'b0;
   end
   task automatic half();
      repeat (6) @(negedge clock_i);
   endtask
   task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
                       output logic [7:0] q);
      logic [23:0] w;
      w = {rd, 2'b00, a, wd};
      q = 8'h00;
      cs_n_o = 1'b0;
      data_oe_o = 1'b1;
      for (int i = 23; i >= 0; i--)
      begin
         sclk_o = 1'b0;
         data_o = w[i];
         if (rd && i < 8)
            data_oe_o = 1'b0;
         half();
         if (i < 8)
            q[i] = data_i;
         sclk_o = 1'b1;
         half();
      end
      sclk_o = 1'b0;
      half();
      cs_n_o = 1'b1;
      data_oe_o = 1'b0;
      half();
   endtask
endmodule // host_model

// ===== tb/testbench.sv
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import rx_ctrl_pkg::*;
   logic clk, nrst, pin, sref, syn_n, alt, sclk, csn, h_do, h_oe, d_o, d_oe, pin_d;
   logic [10:0] smp, s_o;
   logic [1:0]  cm, lm;
   logic        pll, ser, lck, lrst, drv, rqe, rqw, dvr, ral, srq;
   logic [2:0]  csel;
   logic [5:0]  tun;
   logic [7:0]  mfo, emp, q, v, pm;
   logic [15:0] dcv, dh;
   int          seed, err_count, check_count, n_div, n_ral;
   assign pin_d = d_oe ? d_o : (h_oe ? h_do : alt);
   host_model i_host (.clock_i(clk), .data_i(pin_d), .sclk_o(sclk), .cs_n_o(csn),
      .data_o(h_do), .data_oe_o(h_oe));
   receiver_mode_control_bank i_dut (.clock_i(clk), .nrst_i(nrst), .spi_clk_i(sclk),
      .spi_cs_n_i(csn), .spi_data_i(pin_d), .spi_data_o(d_o), .spi_data_oe_o(d_oe),
      .power_down_pin_i(pin), .sysref_i(sref), .link_sync_request_n_i(syn_n),
      .sample_i(smp), .sample_o(s_o), .converter_mode_o(cm), .link_mode_o(lm),
      .pll_on_o(pll), .serializer_on_o(ser), .link_clocks_on_o(lck), .link_reset_o(lrst),
      .driver_power_down_o(drv), .control_bit_select_o(csel), .requantizer_enable_o(rqe),
      .requantizer_wide_o(rqw), .requantizer_tuning_o(tun), .divider_reset_o(dvr),
      .link_realign_o(ral), .sync_request_o(srq), .multiframe_offset_o(mfo),
      .transmit_emphasis_o(emp), .dc_value_o(dcv));
   // ****************************************
   // Helpers
   // ****************************************
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(negedge clk) alt <= ~alt;
   always @(posedge clk) if (dvr === 1'b1) n_div++;
   always @(posedge clk) if (ral === 1'b1) n_ral++;
   function automatic logic [10:0] exp_s(input logic [10:0] s, input logic [7:0] m);
      logic [10:0] r;
      r = m[2] ? ~s : s;
      if (m[1:0] == 2'b00)
         r[10] = ~r[10];
      return m[4] ? 11'h000 : r;
   endfunction
   function automatic logic [10:0] sat_s(input logic [10:0] s, input logic [15:0] d);
      int e;
      e = int'($signed(s)) - int'($signed(d));
      if (e > 1023)
         e = 1023;
      else if (e < -1024)
         e = -1024;
      return 11'(e);
   endfunction
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      i_host.xfer(1'b0, a, d, q);
   endtask
   task automatic rdc(input logic [12:0] a, input logic [7:0] e);
      i_host.xfer(1'b1, a, 8'h00, q);
      `CHK("register", e, q)
   endtask
   task automatic go(input logic [12:0] a, input logic [7:0] d);
      wr(a, d);
      wr(ADDR_XFER, 8'h01);
      wt(4);
   endtask
   task automatic pulse(input int n);
      repeat (n)
      begin
         sref = 1'b1;
         wt(4);
         sref = 1'b0;
         wt(4);
      end
      wt(4);
   endtask
   task automatic done(input string s);
      $display("test %s finished, %0d mismatches so far", s, err_count);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (100000) @(posedge clk);
      err_count++;
      summarize();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      {nrst, pin, sref, smp, alt, n_div, n_ral, err_count, check_count} = '0;
      syn_n = 1'b1;
      seed = 9;
      wt(5);
      nrst = 1'b1;
      wt(6);
      `CHK("emphasis out", 8'h04, emp)
      rdc(ADDR_EMPH, 8'h04);
      rdc(ADDR_LMFC, 8'h00);
      rdc(ADDR_DRV, 8'h00);
      v = 8'($random(seed));
      wr(ADDR_SCRATCH, v);
      rdc(ADDR_SCRATCH, v);
      v = 8'($random(seed));
      wr(ADDR_LANE_CHECKSUM, v);
      rdc(ADDR_LANE_CHECKSUM, v);
      rdc(13'h0050, 8'h00);
      go(ADDR_EMPH, 8'h14);
      `CHK("emphasis out", 8'h14, emp)
      v = 8'($random(seed));
      wr(ADDR_LMFC, v);
      `CHK("offset held", 8'h00, mfo)
      go(ADDR_LMFC, v);
      `CHK("offset out", v, mfo)
      rdc(ADDR_XFER, 8'h00);
      done("registers");
      for (int c = 0; c < 3; c++)
         for (int l = 0; l < 3; l++)
         begin
            go(ADDR_PDM, {4'h0, 2'(l), 2'(c)});
            `CHK("conv mode", 2'(c), cm)
            `CHK("link mode", 2'(l), lm)
            `CHK("pll", (l != 1), pll)
            `CHK("serializer", (l == 0), ser)
            `CHK("link clocks", (l == 0), lck)
            `CHK("link reset", (l != 0), lrst)
         end
      done("power");
      for (int k = 0; k < 3; k++)
      begin
         pm = (k == 0) ? 8'h00 : ((k == 1) ? 8'h30 : 8'h20);
         go(ADDR_PDM, pm);
         pin = 1'b1;
         wt(5);
         `CHK("pin conv", (k == 0) ? PWR_DOWN : PWR_STANDBY, cm)
         `CHK("pin link", (k == 2) ? PWR_NORMAL : ((k == 0) ? PWR_DOWN : PWR_STANDBY), lm)
         pin = 1'b0;
         wt(5);
      end
      done("pin");
      for (int k = 0; k < 4; k++)
      begin
         pm = {3'($random(seed)), 5'((k == 0) ? 0 : ((k == 1) ? 1 : ((k == 2) ? 5 : 16)))};
         go(ADDR_OMC, pm);
         `CHK("cs select", pm[7:5], csel)
         repeat (20)
         begin
            smp = 11'($random(seed));
            wt(1);
            `CHK("sample", exp_s(smp, pm), s_o)
         end
      end
      done("data");
      go(ADDR_RQT, 8'h3f);
      go(ADDR_RQC, 8'h03);
      `CHK("rq on", 1'b1, rqe)
      `CHK("rq wide", 1'b1, rqw)
      `CHK("tuning", 6'd33, tun)
      go(ADDR_RQC, 8'h00);
      `CHK("rq off", 1'b0, rqe)
      `CHK("tuning", 6'd56, tun)
      done("requantizer");
      // Driver is powered down around link configuration changes
      go(ADDR_DRV, 8'h01);
      `CHK("driver pd", 1'b1, drv)
      go(ADDR_LSC, 8'h0a);
      {n_div, n_ral} = '0;
      pulse(3);
      `CHK("div resets", 3, n_div)
      `CHK("realigns", 3, n_ral)
      go(ADDR_LSC, 8'h06);
      {n_div, n_ral} = '0;
      pulse(3);
      `CHK("div once", 1, n_div)
      `CHK("no realign", 0, n_ral)
      go(ADDR_LSC, 8'h18);
      {n_div, n_ral} = '0;
      syn_n = 1'b0;
      pulse(2);
      `CHK("sysref off", 0, n_div + n_ral)
      `CHK("sync buf off", 1'b0, srq)
      syn_n = 1'b1;
      go(ADDR_LSC, 8'h11);
      n_ral = 0;
      syn_n = 1'b0;
      wt(5);
      `CHK("sync req", 1'b1, srq)
      `CHK("sync realign", 1, n_ral)
      syn_n = 1'b1;
      go(ADDR_DRV, 8'h00);
      `CHK("driver on", 1'b0, drv)
      done("link");
      // Constant input pushes the estimate away from zero before it is frozen
      smp = 11'h3ff;
      wt(2000);
      go(ADDR_OCC, 8'h40);
      dh = dcv;
      `CHK("dc moved", 1'b1, dh != 16'h0000)
      repeat (20)
      begin
         smp = 11'($random(seed));
         wt(1);
      end
      `CHK("dc frozen", dh, dcv)
      go(ADDR_OCC, 8'h74);
      `CHK("dc bw 13", 16'($signed(dh) >>> 13), dcv)
      go(ADDR_OCC, 8'h7c);
      `CHK("dc bw 15", 16'($signed(dh) >>> 13), dcv)
      go(ADDR_OMC, 8'h01);
      go(ADDR_OCC, 8'h42);
      repeat (20)
      begin
         smp = 11'($random(seed));
         wt(1);
         `CHK("dc sample", sat_s(smp, dh), s_o)
      end
      done("dc");
      summarize();
   end
endmodule // testbench
